// file: rtl/slsb_top.sv
// Purpose: Keeps error and self-test history and streams log sectors.
// Assumes: Event inputs come from logic on core_clk.
// Notes: A sector is 512 bytes, one per cycle, checksum last.
`default_nettype none
module slsb_top (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic rd_start,
	input wire logic [1:0] rd_sel,
	output logic rd_busy_q,
	output logic rd_valid_q,
	output logic rd_last_q,
	output logic [7:0] rd_data_q,
	input wire logic err_wr,
	input wire logic [63:0] err_cmd_tf,
	input wire logic [31:0] err_time_ms,
	input wire logic [55:0] err_tf,
	input wire logic [7:0] err_state,
	input wire logic [15:0] err_hours,
	input wire logic st_wr,
	input wire logic [7:0] st_num,
	input wire logic [3:0] st_outcome,
	input wire logic [3:0] st_remain,
	input wire logic [15:0] st_hours,
	input wire logic [7:0] st_errno,
	input wire logic [31:0] st_lba,
	input wire logic [7:0] quick_min,
	input wire logic [7:0] comp_min,
	output logic [7:0] quick_min_q,
	output logic [7:0] comp_min_q,
	output logic [15:0] errlog_cap_q
);
	slsb_pkg::slsb_state_t state_q, state_d;
	logic [1:0] sel_q, sel_d;
	logic [8:0] idx_q, idx_d;
	logic rd_valid_d, rd_last_d;
	logic [7:0] rd_data_d;
	logic [2:0] err_ptr_q, err_ptr_d;
	logic [15:0] err_cnt_q, err_cnt_d;
	logic [4:0] st_idx_q, st_idx_d;
	logic [8*slsb_pkg::ERR_BYTES-1:0] err_mem_q [slsb_pkg::ERR_NUM];
	logic [8*slsb_pkg::ERR_BYTES-1:0] err_mem_d [slsb_pkg::ERR_NUM];
	logic [8*slsb_pkg::ST_BYTES-1:0] st_mem_q [slsb_pkg::ST_NUM];
	logic [8*slsb_pkg::ST_BYTES-1:0] st_mem_d [slsb_pkg::ST_NUM];
	logic [8*slsb_pkg::ERR_BYTES-1:0] err_new;
	logic [8*slsb_pkg::ST_BYTES-1:0] st_new;
	logic [7:0] byte_v;
	logic [7:0] chk;
	logic cs_clr, cs_add;

	// Snapshot image: command taskfile, timestamp, error taskfile, state, hours.
	assign err_new = {err_hours, err_state, err_tf, err_time_ms, err_cmd_tf};
	// Status byte packs the outcome above the remaining fraction.
	assign st_new = {st_lba, st_errno, st_hours, st_outcome, st_remain, st_num};

	// Pointers wrap so the oldest entry is the next one overwritten.
	always_comb begin
		err_ptr_d = err_ptr_q;
		err_cnt_d = err_cnt_q;
		st_idx_d = st_idx_q;
		if (err_wr) begin
			err_ptr_d = (err_ptr_q == 3'(slsb_pkg::ERR_NUM)) ? 3'h1 : 3'(err_ptr_q + 3'h1);
			if (err_cnt_q != 16'hFFFF) begin
				err_cnt_d = 16'(err_cnt_q + 16'h0001);
			end
		end
		if (st_wr) begin
			st_idx_d = (st_idx_q == 5'(slsb_pkg::ST_NUM)) ? 5'h01 : 5'(st_idx_q + 5'h01);
		end
	end

	for (genvar g = 0; g < slsb_pkg::ERR_NUM; g++) begin : g_err
		assign err_mem_d[g] = (err_wr && err_ptr_d == 3'(g + 1)) ? err_new : err_mem_q[g];
		always_ff @(posedge core_clk) begin
			if (!resetn) begin
				err_mem_q[g] <= '0;
			end else begin
				err_mem_q[g] <= err_mem_d[g];
			end
		end
	end

	for (genvar g = 0; g < slsb_pkg::ST_NUM; g++) begin : g_st
		assign st_mem_d[g] = (st_wr && st_idx_d == 5'(g + 1)) ? st_new : st_mem_q[g];
		always_ff @(posedge core_clk) begin
			if (!resetn) begin
				st_mem_q[g] <= '0;
			end else begin
				st_mem_q[g] <= st_mem_d[g];
			end
		end
	end

	// Byte image of the selected sector at the current index.
	always_comb begin
		int o;
		int e;
		int f;
		int k;
		o = 0;
		e = 0;
		f = 0;
		k = -1;
		byte_v = 8'h00;
		case (sel_q)
			slsb_pkg::SLSB_LOG_DIR: begin
				if (idx_q == 9'h000) begin
					byte_v = slsb_pkg::DIR_VERSION[7:0];
				end else if (idx_q == 9'h001) begin
					byte_v = slsb_pkg::DIR_VERSION[15:8];
				end else if (idx_q == slsb_pkg::DIR_CNT01_POS) begin
					byte_v = slsb_pkg::DIR_CNT01;
				end else if (idx_q == slsb_pkg::DIR_CNT06_POS) begin
					byte_v = slsb_pkg::DIR_CNT06;
				end else if (idx_q >= slsb_pkg::DIR_VEND_LO && idx_q <= slsb_pkg::DIR_VEND_HI
						&& !idx_q[0]) begin
					byte_v = slsb_pkg::DIR_VEND_CNT;
				end
			end
			slsb_pkg::SLSB_LOG_ERR: begin
				if (idx_q == 9'h000) begin
					byte_v = slsb_pkg::ERR_VERSION;
				end else if (idx_q == 9'h001) begin
					byte_v = {5'h00, err_ptr_q};
				end else if (idx_q < slsb_pkg::ERR_CNT_POS) begin
					o = int'(idx_q - slsb_pkg::ERR_BASE);
					e = o / slsb_pkg::ERR_SIZE;
					f = o % slsb_pkg::ERR_SIZE;
					if (f >= slsb_pkg::ERR_CMD_OFS && f < slsb_pkg::ERR_CMD_OFS + 12) begin
						k = f - slsb_pkg::ERR_CMD_OFS;
					end else if (f >= slsb_pkg::ERR_TF_OFS && f < slsb_pkg::ERR_TF_OFS + 7) begin
						k = f - slsb_pkg::ERR_TF_OFS + 12;
					end else if (f >= slsb_pkg::ERR_STATE_OFS) begin
						k = f - slsb_pkg::ERR_STATE_OFS + 19;
					end
					if (k >= 0) begin
						byte_v = err_mem_q[e][k*8 +: 8];
					end
				end else if (idx_q == slsb_pkg::ERR_CNT_POS) begin
					byte_v = err_cnt_q[7:0];
				end else if (idx_q == 9'(slsb_pkg::ERR_CNT_POS + 9'h001)) begin
					byte_v = err_cnt_q[15:8];
				end
			end
			slsb_pkg::SLSB_LOG_ST: begin
				if (idx_q == 9'h000) begin
					byte_v = slsb_pkg::ST_REVISION[7:0];
				end else if (idx_q == 9'h001) begin
					byte_v = slsb_pkg::ST_REVISION[15:8];
				end else if (idx_q <= slsb_pkg::ST_END) begin
					o = int'(idx_q - slsb_pkg::ST_BASE);
					e = o / slsb_pkg::ST_SIZE;
					f = o % slsb_pkg::ST_SIZE;
					if (f < slsb_pkg::ST_BYTES) begin
						byte_v = st_mem_q[e][f*8 +: 8];
					end
				end else if (idx_q == slsb_pkg::ST_IDX_POS) begin
					byte_v = {3'h0, st_idx_q};
				end
			end
			default: begin
				byte_v = 8'h00;
			end
		endcase
	end

	always_comb begin
		state_d = state_q;
		sel_d = sel_q;
		idx_d = idx_q;
		rd_valid_d = 1'b0;
		rd_last_d = 1'b0;
		rd_data_d = 8'h00;
		cs_clr = 1'b0;
		cs_add = 1'b0;
		case (state_q)
			slsb_pkg::SLSB_IDLE: begin
				if (rd_start) begin
					state_d = slsb_pkg::SLSB_SEND;
					sel_d = rd_sel;
					idx_d = 9'h000;
					cs_clr = 1'b1;
				end
			end
			slsb_pkg::SLSB_SEND: begin
				rd_valid_d = 1'b1;
				idx_d = 9'(idx_q + 9'h001);
				if (idx_q == slsb_pkg::SECT_LAST) begin
					rd_data_d = chk;
					rd_last_d = 1'b1;
					state_d = slsb_pkg::SLSB_IDLE;
				end else begin
					rd_data_d = byte_v;
					cs_add = 1'b1;
				end
			end
			default: begin
				state_d = slsb_pkg::SLSB_IDLE;
			end
		endcase
	end

	slsb_csum u_csum (
		.core_clk(core_clk),
		.resetn(resetn),
		.clr(cs_clr),
		.add(cs_add),
		.din(byte_v),
		.chk(chk)
	);

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_q <= slsb_pkg::SLSB_IDLE;
			sel_q <= 2'h0;
			idx_q <= 9'h000;
			rd_busy_q <= 1'b0;
			rd_valid_q <= 1'b0;
			rd_last_q <= 1'b0;
			rd_data_q <= 8'h00;
			err_ptr_q <= 3'h0;
			err_cnt_q <= 16'h0000;
			st_idx_q <= 5'h00;
			quick_min_q <= 8'h00;
			comp_min_q <= 8'h00;
			errlog_cap_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			sel_q <= sel_d;
			idx_q <= idx_d;
			rd_busy_q <= (state_d == slsb_pkg::SLSB_SEND);
			rd_valid_q <= rd_valid_d;
			rd_last_q <= rd_last_d;
			rd_data_q <= rd_data_d;
			err_ptr_q <= err_ptr_d;
			err_cnt_q <= err_cnt_d;
			st_idx_q <= st_idx_d;
			quick_min_q <= quick_min;
			comp_min_q <= comp_min;
			errlog_cap_q <= slsb_pkg::ERRLOG_CAP;
		end
	end
endmodule : slsb_top
`default_nettype wire

// file: rtl/slsb_pkg.sv
// Purpose: Shared constants for the log sector builder.
// Assumes: One byte per clock on the read side.
// Notes: Multi-byte fields are sent least significant byte first.
`default_nettype none
package slsb_pkg;
	typedef enum logic [1:0] {
		SLSB_LOG_DIR = 2'h0,
		SLSB_LOG_ERR = 2'h1,
		SLSB_LOG_ST = 2'h2
	} slsb_log_t;
	typedef enum logic {
		SLSB_IDLE = 1'b0,
		SLSB_SEND = 1'b1
	} slsb_state_t;
	localparam logic [8:0] SECT_LAST = 9'h1FF;
	localparam logic [15:0] ERRLOG_CAP = 16'h0001;
	localparam logic [15:0] DIR_VERSION = 16'h0001;
	localparam logic [8:0] DIR_CNT01_POS = 9'h002;
	localparam logic [8:0] DIR_CNT06_POS = 9'h00C;
	localparam logic [7:0] DIR_CNT01 = 8'h01;
	localparam logic [7:0] DIR_CNT06 = 8'h01;
	localparam logic [8:0] DIR_VEND_LO = 9'h100;
	localparam logic [8:0] DIR_VEND_HI = 9'h13F;
	localparam logic [7:0] DIR_VEND_CNT = 8'h00;
	localparam logic [7:0] ERR_VERSION = 8'h01;
	localparam int ERR_NUM = 5;
	localparam int ERR_SIZE = 90;
	localparam int ERR_BYTES = 22;
	localparam logic [8:0] ERR_BASE = 9'h002;
	localparam logic [8:0] ERR_CNT_POS = 9'h1C4;
	localparam int ERR_CMD_OFS = 48;
	localparam int ERR_TF_OFS = 61;
	localparam int ERR_STATE_OFS = 87;
	localparam int ST_NUM = 21;
	localparam int ST_SIZE = 24;
	localparam int ST_BYTES = 9;
	localparam logic [8:0] ST_BASE = 9'h002;
	localparam logic [8:0] ST_END = 9'h1F9;
	localparam logic [8:0] ST_IDX_POS = 9'h1FC;
	localparam logic [15:0] ST_REVISION = 16'h0001;
	localparam logic [7:0] ST_RUNNING = 8'h0F;
endpackage : slsb_pkg
`default_nettype wire

// file: rtl/slsb_csum.sv
// Purpose: Running byte sum that yields the closing checksum of a sector.
// Assumes: clr and add never rise together.
// Notes: Carries above bit 7 are dropped, so only the low byte of the sum survives.
`default_nettype none
module slsb_csum (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clr,
	input wire logic add,
	input wire logic [7:0] din,
	output logic [7:0] chk
);
	logic [7:0] sum_q;
	logic [7:0] sum_d;

	always_comb begin
		sum_d = sum_q;
		if (clr) begin
			sum_d = 8'h00;
		end else if (add) begin
			sum_d = 8'(sum_q + din);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sum_q <= 8'h00;
		end else begin
			sum_q <= sum_d;
		end
	end

	assign chk = 8'(~sum_q + 8'h01);
endmodule : slsb_csum
`default_nettype wire

// file: bench/slsb_host.sv
// Purpose: Host side model that captures one streamed log sector.
// Assumes: Bytes arrive one per clock while valid is high.
// Notes: Done stays high until the next request.
`default_nettype none
module slsb_host (
	input wire logic core_clk,
	input wire logic req,
	input wire logic rd_valid_q,
	input wire logic rd_last_q,
	input wire logic [7:0] rd_data_q,
	output logic done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [512];
	int n = 0;
	// Judging attributes against thresholds is left to the host firmware above this model.
	initial done = 1'b0;
	always @(posedge core_clk) begin
		if (req)
			done <= 1'b0;
		if (rd_valid_q) begin
			mem[n] <= rd_data_q;
			n <= rd_last_q ? 0 : n + 1;
		end
		if (rd_last_q)
			done <= 1'b1;
	end
endmodule : slsb_host
`default_nettype wire

// file: bench/slsb_top_assertions.sv
// Purpose: Port level checks of the sector stream, the constant capability word and the registered duration copies.
// Assumes: One clock with a synchronous active low reset.
// Notes: Helper registers track the byte index and the running sum.
`default_nettype none
module slsb_chk (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic rd_start,
	input wire logic rd_busy_q,
	input wire logic rd_valid_q,
	input wire logic rd_last_q,
	input wire logic [7:0] rd_data_q,
	input wire logic [7:0] quick_min,
	input wire logic [7:0] comp_min,
	input wire logic [7:0] quick_min_q,
	input wire logic [7:0] comp_min_q,
	input wire logic [15:0] errlog_cap_q
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] idx_q, idx_d;
	logic [7:0] sum_q, sum_d;
	always_comb begin
		idx_d = rd_valid_q ? idx_q + 9'h001 : 9'h000;
		sum_d = rd_valid_q ? sum_q + rd_data_q : 8'h00;
	end
	always_ff @(posedge core_clk) begin
		idx_q <= resetn ? idx_d : 9'h000;
		sum_q <= resetn ? sum_d : 8'h00;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence s_take;
		rd_start && !rd_busy_q;
	endsequence
	sequence s_burst;
		rd_valid_q [*8];
	endsequence
	// The first byte is registered one edge after the take, so it is sampled two edges on.
	a_take_burst: assert property (s_take |-> ##2 s_burst)
		else $error("stream did not follow a start");
	a_last_index: assert property (rd_last_q |-> rd_valid_q && idx_q == 9'h1FF)
		else $error("last flag not on byte 511");
	a_index_last: assert property (rd_valid_q && idx_q == 9'h1FF |-> rd_last_q)
		else $error("byte 511 without last flag");
	a_sum_zero: assert property (rd_last_q |-> 8'(sum_q + rd_data_q) == 8'h00)
		else $error("sector sum not zero");
	a_last_idle: assert property (rd_last_q |=> !rd_valid_q && !rd_busy_q)
		else $error("stream ran past checksum");
	// Busy drops together with the checksum byte, so the next take can follow at once.
	a_busy_valid: assert property (rd_valid_q |-> rd_busy_q == !rd_last_q)
		else $error("busy level wrong during stream");
	a_cap_word: assert property ($past(resetn) |-> errlog_cap_q == 16'h0001)
		else $error("capability word wrong");
	a_min_copy: assert property ($past(resetn) |-> quick_min_q == $past(quick_min)
		&& comp_min_q == $past(comp_min))
		else $error("duration copy wrong");
endmodule : slsb_chk
bind slsb_top slsb_chk slsb_chk_i (.core_clk, .resetn, .rd_start, .rd_busy_q, .rd_valid_q,
	.rd_last_q, .rd_data_q, .quick_min, .comp_min, .quick_min_q, .comp_min_q, .errlog_cap_q);
`default_nettype wire

// file: bench/slsb_top_tb.sv
// Purpose: Self checking bench for the log sector builder.
// Assumes: Sectors are captured by the host model.
// Notes: Self-test fields are packed so byte n maps to offset n; error snapshot byte n maps to offset ofs(n).
`default_nettype none
module slsb_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic rd_start = 1'b0;
	logic [1:0] rd_sel = 2'h0;
	logic err_wr = 1'b0;
	logic st_wr = 1'b0;
	logic [175:0] eb = '0;
	logic [71:0] sb = '0;
	logic [7:0] quick_min = 8'h1E;
	logic [7:0] comp_min = 8'h5A;
	logic rd_busy_q, rd_valid_q, rd_last_q, done;
	logic [7:0] rd_data_q, quick_min_q, comp_min_q;
	logic [15:0] errlog_cap_q;
	int bad_count = 0;
	int tests_run = 0;
	int cyc = 0;
	slsb_top slsb_top_i (.core_clk, .resetn, .rd_start, .rd_sel, .rd_busy_q, .rd_valid_q,
		.rd_last_q, .rd_data_q, .err_wr, .err_cmd_tf(eb[63:0]), .err_time_ms(eb[95:64]),
		.err_tf(eb[151:96]), .err_state(eb[159:152]), .err_hours(eb[175:160]), .st_wr,
		.st_num(sb[7:0]), .st_outcome(sb[15:12]), .st_remain(sb[11:8]), .st_hours(sb[31:16]),
		.st_errno(sb[39:32]), .st_lba(sb[71:40]), .quick_min, .comp_min, .quick_min_q,
		.comp_min_q, .errlog_cap_q);
	slsb_host slsb_host_i (.core_clk, .req(rd_start), .rd_valid_q, .rd_last_q, .rd_data_q,
		.done);
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count = bad_count + 1;
			conclude();
		end
	end
	task conclude;
		if (bad_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : conclude
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic int ofs(int n);
		return n < 12 ? 48 + n : (n < 19 ? 49 + n : 68 + n);
	endfunction : ofs
	task automatic rd(input logic [1:0] sel);
		logic [7:0] s;
		s = 8'h00;
		rd_sel <= sel;
		rd_start <= 1'b1;
		@(posedge core_clk);
		rd_start <= 1'b0;
		for (int i = 0; i < 600; i++) begin
			@(posedge core_clk);
			if (done === 1'b1)
				break;
		end
		for (int a = 0; a < 512; a++)
			s = s + slsb_host_i.mem[a];
		check("csum", s, 16'h0000);
	endtask : rd
	task t_dir;
		rd(2'h0);
		check("ver", {slsb_host_i.mem[1], slsb_host_i.mem[0]}, 16'h0001);
		check("cnt01", slsb_host_i.mem[2], slsb_pkg::DIR_CNT01);
		check("cnt06", slsb_host_i.mem[12], slsb_pkg::DIR_CNT06);
		for (int a = 256; a < 320; a++)
			check("slot", slsb_host_i.mem[a], 16'h0000);
		check("cap", errlog_cap_q, 16'h0001);
		check("quick", quick_min_q, 16'h001E);
		check("comp", comp_min_q, 16'h005A);
		rd(2'h3);
	endtask : t_dir
	task t_err;
		rd(2'h1);
		check("errver", slsb_host_i.mem[0], 16'h0001);
		check("ptr0", slsb_host_i.mem[1], 16'h0000);
		for (int j = 1; j <= 6; j++) begin
			for (int n = 0; n < 22; n++)
				eb[8*n +: 8] <= 8'(16 * j + n);
			err_wr <= 1'b1;
			@(posedge core_clk);
		end
		err_wr <= 1'b0;
		@(posedge core_clk);
		rd(2'h1);
		check("ptr", slsb_host_i.mem[1], 16'h0001);
		check("count", {slsb_host_i.mem[453], slsb_host_i.mem[452]}, 16'h0006);
		for (int k = 1; k <= 5; k++)
			for (int n = 0; n < 22; n++)
				check("snap", slsb_host_i.mem[2 + 90 * (k - 1) + ofs(n)],
					8'(16 * (k == 1 ? 6 : k) + n));
	endtask : t_err
	task t_st;
		rd(2'h2);
		check("rev", {slsb_host_i.mem[1], slsb_host_i.mem[0]}, 16'h0001);
		check("idx0", slsb_host_i.mem[508], 16'h0000);
		for (int j = 1; j <= 21; j++) begin
			for (int n = 0; n < 9; n++)
				sb[8*n +: 8] <= n == 1 ? (j == 21 ? 8'hF3 : 8'h23) : 8'(11 * j + n);
			st_wr <= 1'b1;
			@(posedge core_clk);
		end
		st_wr <= 1'b0;
		@(posedge core_clk);
		rd(2'h2);
		check("idx", slsb_host_i.mem[508], 16'h0015);
		for (int k = 1; k <= 21; k += 20)
			for (int n = 0; n < 9; n++)
				check("desc", slsb_host_i.mem[2 + 24 * (k - 1) + n],
					n == 1 ? (k == 21 ? 8'hF3 : 8'h23) : 8'(11 * k + n));
		sb <= {9{8'hA5}};
		quick_min <= 8'h2D;
		comp_min <= 8'hB4;
		st_wr <= 1'b1;
		@(posedge core_clk);
		st_wr <= 1'b0;
		@(posedge core_clk);
		rd(2'h2);
		check("wrap", slsb_host_i.mem[508], 16'h0001);
		check("over", slsb_host_i.mem[3], 16'h00A5);
		check("quick2", quick_min_q, 16'h002D);
		check("comp2", comp_min_q, 16'h00B4);
	endtask : t_st
	initial begin
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		@(posedge core_clk);
		t_dir();
		t_err();
		t_st();
		conclude();
	end
endmodule : slsb_top_tb
`default_nettype wire
